// file: logic/rsq_top.v
// Receive signal qualifiers: preamble quality, sync qualifier, RSSI and carrier sense
//Contract
//- Sync select picks none, 15/16, 16/16, 30/32
//- Upper codes add carrier detect requirement
//- Quality counter plus one, minus eight
//- Sync allowed when counter exceeds four times threshold
//- Zero threshold disables quality gate
//- Quality hit flag in status, pin code 8
//- MSK inverts sync word and data
//- Deviation ignored in on-off/amplitude keying
//- RSSI tracks until sync, then freezes, except when sync select is none
//- RSSI is two's complement half-dB
//- RSSI sample every 8 times two^length
//- Last packet RSSI appended as status byte
//- Absolute mode threshold with hysteresis
//- Relative mode set on step up, cleared on step down
//- Carrier modes search sync only above threshold
//- Carrier detect on pin code 14, status
//- Absolute offset shifts threshold from minus eight to plus seven dB
//- Threshold from gain caps, offset, level target
//- Relative step off, 6, 10 or 14 dB
//- No FIFO writes or filtering before sync
`timescale 1ns/100ps
`include "rsq_defines.vh"
module rsq_top #(
    parameter SYNC_W = 32
) (
    // Clock and reset
    input wire MCLK_IN,
    input wire RST_N_IN,
    // Register port
    input wire [7:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [7:0] RDATA_OUT,
    // Demodulator bit stream
    input wire BIT_VALID_IN,
    input wire BIT_IN,
    input wire RX_ENTER_IN,
    input wire PKT_END_IN,
    // Gain chain sample at channel filter tick
    input wire CHAN_TICK_IN,
    input wire [7:0] RSSI_RAW_IN,
    // Deviation request from the modem
    input wire [7:0] DEV_IN,
    // Qualified outputs
    output reg BIT_OUT,
    output reg [7:0] DEV_OUT,
    output wire SYNC_FOUND_OUT,
    output wire FIFO_WR_EN_OUT,
    output reg GPO_OUT
);
    // Configuration registers
    reg [7:0] modem_ff;
    reg [7:0] pktctl_ff;
    reg [7:0] gain0_ff;
    reg [7:0] gain1_ff;
    reg [7:0] gain2_ff;
    reg [7:0] pinsel_ff;
    // Preamble quality estimator and sync search
    reg [7:0] pq_cnt_ff;
    reg [7:0] nxt_pq_cnt;
    reg prev_bit_ff;
    reg [SYNC_W-1:0] shreg_ff;
    reg [5:0] bits_seen_ff;
    reg sync_ff;
    // Level measurement and carrier sense
    reg [7:0] rssi_ff;
    reg [7:0] prev_rssi_ff;
    reg [7:0] stat0_ff;
    reg [7:0] sample_ff;
    reg [10:0] tick_cnt_ff;
    reg cs_abs_ff;
    reg cs_rel_ff;
    // Set at sync, cleared only on receive entry, so packet end keeps the freeze
    reg rssi_hold_ff;
    reg sample_pend_ff;
    wire [2:0] sync_mode = modem_ff[`RSQ_MODEM_SYNC_LSB +: 3];
    wire [2:0] mod_fmt = modem_ff[`RSQ_MODEM_MOD_LSB +: 3];
    wire [2:0] preamble_quality_threshold_field = pktctl_ff[`RSQ_PKTCTL_PQT_LSB +: 3];
    wire [2:0] flen = gain0_ff[`RSQ_GAIN0_FLEN_LSB +: 3];
    wire [3:0] abs_off = gain1_ff[`RSQ_GAIN1_ABS_LSB +: 4];
    wire [1:0] rel_sel = gain1_ff[`RSQ_GAIN1_REL_LSB +: 2];
    wire [2:0] magn = gain2_ff[`RSQ_GAIN2_MAGN_LSB +: 3];
    wire [2:0] lna = gain2_ff[`RSQ_GAIN2_LNA_LSB +: 3];
    wire [1:0] dvga = gain2_ff[`RSQ_GAIN2_DVGA_LSB +: 2];
    // Sync word reference is zero-justified; software sees only the qualifier
    parameter [SYNC_W-1:0] SYNC_WORD = 32'hd391_d391;
    wire carrier = cs_abs_ff | cs_rel_ff;
    wire rx_bit = (mod_fmt == `RSQ_MOD_MSK) ? ~BIT_IN : BIT_IN;
    wire [7:0] pq_thr = {3'h0, preamble_quality_threshold_field, 2'h0};
    wire pq_hit = (pq_cnt_ff > pq_thr);
    wire pq_ok = (preamble_quality_threshold_field == 3'h0) | pq_hit;
    wire cs_ok = ~sync_mode[2] | carrier;
    // Bit mismatch counts by popcount of the xor
    wire [SYNC_W-1:0] diff;
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g = g + 1) begin : g_diff
            assign diff[g] = shreg_ff[g] ^ SYNC_WORD[g];
        end
    endgenerate
    reg [5:0] err16, err32;
    integer i;
    always @* begin
        err16 = 6'h00;
        err32 = 6'h00;
        for (i = 0; i < SYNC_W; i = i + 1) begin
            // Short criteria look only at the newest 16 bits
            if (i < 16) begin
                err16 = err16 + {5'h00, diff[i]};
            end
            err32 = err32 + {5'h00, diff[i]};
        end
    end
    reg crit;
    always @* begin
        // Bit counts keep a window of stale bits from matching after entry
        case (sync_mode[1:0])
            2'h0: begin
                crit = 1'b1;
            end
            2'h1: begin
                crit = (bits_seen_ff >= 6'd16) && (err16 <= 6'd1);
            end
            2'h2: begin
                crit = (bits_seen_ff >= 6'd16) && (err16 == 6'd0);
            end
            default: begin
                crit = (bits_seen_ff >= 6'd32) && (err32 <= 6'd2);
            end
        endcase
    end
    wire sync_det = crit & pq_ok & cs_ok;
    assign SYNC_FOUND_OUT = sync_ff;
    assign FIFO_WR_EN_OUT = sync_ff & BIT_VALID_IN;
    always @* begin
        nxt_pq_cnt = pq_cnt_ff;
        if (BIT_VALID_IN) begin
            // Saturate so a long burst cannot wrap the count around
            if (rx_bit != prev_bit_ff) begin
                nxt_pq_cnt = (pq_cnt_ff == `RSQ_PQ_MAX) ? pq_cnt_ff : pq_cnt_ff + 8'h01;
            end else begin
                nxt_pq_cnt = (pq_cnt_ff < `RSQ_PQ_DEC) ? 8'h00 : pq_cnt_ff - `RSQ_PQ_DEC;
            end
        end
    end
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pq_cnt_ff <= 8'h00;
            prev_bit_ff <= 1'b0;
            shreg_ff <= {SYNC_W{1'b0}};
            bits_seen_ff <= 6'h00;
            sync_ff <= 1'b0;
            BIT_OUT <= 1'b0;
        end else if (RX_ENTER_IN) begin
            // Receive entry restarts the whole search
            pq_cnt_ff <= 8'h00;
            bits_seen_ff <= 6'h00;
            sync_ff <= 1'b0;
        end else if (PKT_END_IN) begin
            // Packet end rearms sync but keeps the quality history
            sync_ff <= 1'b0;
            bits_seen_ff <= 6'h00;
        end else begin
            pq_cnt_ff <= nxt_pq_cnt;
            if (BIT_VALID_IN) begin
                prev_bit_ff <= rx_bit;
                shreg_ff <= {shreg_ff[SYNC_W-2:0], rx_bit};
                BIT_OUT <= rx_bit;
                if (bits_seen_ff != 6'd32) begin
                    bits_seen_ff <= bits_seen_ff + 6'h01;
                end
            end
            // Judged on the settled window, one cycle after the completing bit
            if (!sync_ff && sync_det) begin
                sync_ff <= 1'b1;
            end
        end
    end
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DEV_OUT <= 8'h00;
        end else begin
            DEV_OUT <= (mod_fmt == `RSQ_MOD_ASK) ? 8'h00 : DEV_IN;
        end
    end
    // Sample divider of 8 * 2^length channel ticks
    wire [10:0] tick_top = (11'd8 << flen) - 11'd1;
    wire sample_now = CHAN_TICK_IN && (tick_cnt_ff >= tick_top);
    // Absolute threshold in half-dB, offset sign-extended
    // Linear fit of the gain caps; exact tables differ per data rate
    wire [7:0] off_hd = {{3{abs_off[3]}}, abs_off, 1'b0};
    wire [7:0] abs_thr = 8'h38 + {2'h0, lna, 3'h0} + {3'h0, dvga, 3'h4}
                         - {2'h0, magn, 3'h0} + off_hd;
    reg [7:0] rel_step;
    always @* begin
        case (rel_sel)
            2'h1: begin
                rel_step = 8'h0c;
            end
            2'h2: begin
                rel_step = 8'h14;
            end
            2'h3: begin
                rel_step = 8'h1c;
            end
            default: begin
                rel_step = 8'h00;
            end
        endcase
    end
    // Signed comparisons on two's complement samples
    wire signed [8:0] s_new = {sample_ff[7], sample_ff};
    wire signed [8:0] s_old = {prev_rssi_ff[7], prev_rssi_ff};
    wire signed [8:0] s_thr = {abs_thr[7], abs_thr};
    wire signed [8:0] s_hys = {1'b0, `RSQ_HYST};
    wire signed [8:0] s_step = {1'b0, rel_step};
    wire signed [8:0] s_delta = s_new - s_old;
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tick_cnt_ff <= 11'h000;
            sample_ff <= 8'h80;
            sample_pend_ff <= 1'b0;
        end else begin
            // Pending strobe lets the new sample settle before it is used
            sample_pend_ff <= sample_now;
            if (CHAN_TICK_IN) begin
                tick_cnt_ff <= sample_now ? 11'h000 : tick_cnt_ff + 11'h001;
            end
            if (sample_now) begin
                sample_ff <= RSSI_RAW_IN;
            end
        end
    end
    // Freeze covers the cycle in which sync rises as well
    wire rssi_frozen = rssi_hold_ff | (sync_ff & (sync_mode[1:0] != 2'h0));
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            prev_rssi_ff <= 8'h80;
            rssi_ff <= 8'h80;
            stat0_ff <= 8'h00;
            rssi_hold_ff <= 1'b0;
        end else begin
            // Freeze held from sync until the next receive entry
            if (RX_ENTER_IN) begin
                rssi_hold_ff <= 1'b0;
            end else if (sync_ff && sync_mode[1:0] != 2'h0) begin
                rssi_hold_ff <= 1'b1;
            end
            if (sample_pend_ff) begin
                prev_rssi_ff <= sample_ff;
            end
            if ((sample_pend_ff && !rssi_frozen) || RX_ENTER_IN) begin
                rssi_ff <= sample_ff;
            end
            // Track last sample while in packet
            if (sample_pend_ff && sync_ff) begin
                stat0_ff <= sample_ff;
            end
        end
    end
    // Carrier sense is judged once per fresh sample
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cs_abs_ff <= 1'b0;
            cs_rel_ff <= 1'b0;
        end else if (sample_pend_ff) begin
            // Hysteresis band stops chatter near the threshold
            if (s_new > s_thr + s_hys) begin
                cs_abs_ff <= 1'b1;
            end else if (s_new < s_thr - s_hys) begin
                cs_abs_ff <= 1'b0;
            end
            // Step detection; a flat level keeps the last decision
            if (rel_sel == 2'h0) begin
                cs_rel_ff <= 1'b0;
            end else if (s_delta >= s_step) begin
                cs_rel_ff <= 1'b1;
            end else if (s_delta <= -s_step) begin
                cs_rel_ff <= 1'b0;
            end
        end
    end
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            GPO_OUT <= 1'b0;
        end else if (pinsel_ff[5:0] == `RSQ_PIN_PQT) begin
            GPO_OUT <= pq_hit;
        end else if (pinsel_ff[5:0] == `RSQ_PIN_CS) begin
            GPO_OUT <= carrier;
        end else begin
            GPO_OUT <= 1'b0;
        end
    end
    // Configuration writes; status and level registers are read-only
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            modem_ff <= `RSQ_MODEM_RST;
            pktctl_ff <= `RSQ_PKTCTL_RST;
            gain0_ff <= `RSQ_GAIN0_RST;
            gain1_ff <= `RSQ_GAIN1_RST;
            gain2_ff <= `RSQ_GAIN2_RST;
            pinsel_ff <= `RSQ_PINSEL_RST;
        end else if (WR_IN) begin
            if (ADDR_IN == `RSQ_ADDR_MODEM) begin
                modem_ff <= WDATA_IN;
            end else if (ADDR_IN == `RSQ_ADDR_PKTCTL) begin
                pktctl_ff <= WDATA_IN;
            end else if (ADDR_IN == `RSQ_ADDR_GAIN0) begin
                gain0_ff <= WDATA_IN;
            end else if (ADDR_IN == `RSQ_ADDR_GAIN1) begin
                gain1_ff <= WDATA_IN;
            end else if (ADDR_IN == `RSQ_ADDR_GAIN2) begin
                gain2_ff <= WDATA_IN;
            end else if (ADDR_IN == `RSQ_ADDR_PINSEL) begin
                pinsel_ff <= WDATA_IN;
            end
        end
    end
    // Packet status: carrier, quality hit, sync, pin level
    wire [7:0] pkt_status = {1'b0, carrier, pq_hit, sync_ff, 3'h0, GPO_OUT};
    // Read data valid only in the cycle after the strobe, zero otherwise
    reg [7:0] nxt_rdata;
    always @* begin
        nxt_rdata = 8'h00;
        if (RD_IN) begin
            if (ADDR_IN == `RSQ_ADDR_MODEM) begin
                nxt_rdata = modem_ff;
            end else if (ADDR_IN == `RSQ_ADDR_PKTCTL) begin
                nxt_rdata = pktctl_ff;
            end else if (ADDR_IN == `RSQ_ADDR_GAIN0) begin
                nxt_rdata = gain0_ff;
            end else if (ADDR_IN == `RSQ_ADDR_GAIN1) begin
                nxt_rdata = gain1_ff;
            end else if (ADDR_IN == `RSQ_ADDR_GAIN2) begin
                nxt_rdata = gain2_ff;
            end else if (ADDR_IN == `RSQ_ADDR_PINSEL) begin
                nxt_rdata = pinsel_ff;
            end else if (ADDR_IN == `RSQ_ADDR_PKTSTAT) begin
                nxt_rdata = pkt_status;
            end else if (ADDR_IN == `RSQ_ADDR_RSSI) begin
                nxt_rdata = rssi_ff;
            end else if (ADDR_IN == `RSQ_ADDR_STAT0) begin
                // Appended byte only when appending is on
                nxt_rdata = pktctl_ff[`RSQ_PKTCTL_APPEND_BIT] ? stat0_ff : 8'h00;
            end
        end
    end
    // Registered so the host sees a stable byte for the whole cycle
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT <= 8'h00;
        end else begin
            RDATA_OUT <= nxt_rdata;
        end
    end
endmodule // rsq_top

// file: logic/rsq_defines.vh
// Register offsets, field positions and reset values of the receive qualifiers
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH
`define RSQ_ADDR_MODEM 8'h00
`define RSQ_ADDR_PKTCTL 8'h01
`define RSQ_ADDR_GAIN0 8'h02
`define RSQ_ADDR_GAIN1 8'h03
`define RSQ_ADDR_GAIN2 8'h04
`define RSQ_ADDR_PINSEL 8'h05
`define RSQ_ADDR_PKTSTAT 8'h06
`define RSQ_ADDR_RSSI 8'h07
`define RSQ_ADDR_STAT0 8'h08
`define RSQ_MODEM_SYNC_LSB 0
`define RSQ_MODEM_MOD_LSB 4
`define RSQ_PKTCTL_PQT_LSB 5
`define RSQ_PKTCTL_APPEND_BIT 2
`define RSQ_GAIN0_FLEN_LSB 0
`define RSQ_GAIN1_ABS_LSB 0
`define RSQ_GAIN1_REL_LSB 4
`define RSQ_GAIN2_MAGN_LSB 0
`define RSQ_GAIN2_LNA_LSB 3
`define RSQ_GAIN2_DVGA_LSB 6
`define RSQ_MODEM_RST 8'h02
`define RSQ_PKTCTL_RST 8'h04
`define RSQ_GAIN0_RST 8'h01
`define RSQ_GAIN1_RST 8'h00
`define RSQ_GAIN2_RST 8'h03
`define RSQ_PINSEL_RST 8'h00
`define RSQ_MOD_ASK 3'h3
`define RSQ_MOD_MSK 3'h7
`define RSQ_PIN_PQT 6'h08
`define RSQ_PIN_CS 6'h0e
`define RSQ_PQ_DEC 8'h08
`define RSQ_PQ_MAX 8'hff
`define RSQ_HYST 8'h04
`endif

// file: verif/rsq_properties.sv
// Port checker for the receive qualifiers
`timescale 1ns/100ps
module rsq_props #(parameter SYNC_W = 32) (
    // Clock, reset and register port
    input wire MCLK_IN, RST_N_IN, WR_IN, RD_IN,
    input wire [7:0] ADDR_IN, WDATA_IN, RDATA_OUT,
    // Bit stream and results
    input wire BIT_VALID_IN, BIT_IN, RX_ENTER_IN, PKT_END_IN,
    input wire [7:0] DEV_IN, DEV_OUT,
    input wire BIT_OUT, SYNC_FOUND_OUT, FIFO_WR_EN_OUT, GPO_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    reg [2:0] mod_ff;
    reg [5:0] sel_ff;
    // Shadows of the modulation and pin select fields
    always @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mod_ff <= 3'h0;
            sel_ff <= 6'h00;
        end else if (WR_IN && ADDR_IN == 8'h00) begin
            mod_ff <= WDATA_IN[6:4];
        end else if (WR_IN && ADDR_IN == 8'h05) begin
            sel_ff <= WDATA_IN[5:0];
        end
    end
    property p_rd_idle; !RD_IN |=> RDATA_OUT == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
    property p_rd_unmap; RD_IN && ADDR_IN > 8'h08 |=> RDATA_OUT == 8'h00; endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    property p_fifo; FIFO_WR_EN_OUT == (SYNC_FOUND_OUT && BIT_VALID_IN); endproperty
    a_fifo: assert property (p_fifo) else $error("fifo write without sync");
    property p_hold; SYNC_FOUND_OUT && !RX_ENTER_IN && !PKT_END_IN |=> SYNC_FOUND_OUT;
    endproperty
    a_hold: assert property (p_hold) else $error("sync dropped early");
    property p_clear; RX_ENTER_IN || PKT_END_IN |=> !SYNC_FOUND_OUT; endproperty
    a_clear: assert property (p_clear) else $error("sync not cleared");
    property p_dev;
        1 |=> DEV_OUT == (($past(mod_ff) == 3'h3) ? 8'h00 : $past(DEV_IN));
    endproperty
    a_dev: assert property (p_dev) else $error("deviation wrong");
    property p_bit; BIT_VALID_IN |=> BIT_OUT == ($past(BIT_IN) ^ ($past(mod_ff) == 3'h7));
    endproperty
    a_bit: assert property (p_bit) else $error("bit polarity wrong");
    property p_gpo; sel_ff != 6'h08 && sel_ff != 6'h0e |=> !GPO_OUT; endproperty
    a_gpo: assert property (p_gpo) else $error("pin active when unselected");
    property p_stat; RD_IN && ADDR_IN == 8'h06 |=> RDATA_OUT[4] == $past(SYNC_FOUND_OUT);
    endproperty
    a_stat: assert property (p_stat) else $error("status sync bit wrong");
    c_sync: cover property ($rose(SYNC_FOUND_OUT));
    c_fifo: cover property (FIFO_WR_EN_OUT);
    c_gpo: cover property (GPO_OUT);
endmodule // rsq_props
bind rsq_top rsq_props #(.SYNC_W(SYNC_W)) u_props (.*);

// file: verif/rsq_demod.sv
// Demodulator and gain chain model
`timescale 1ns/100ps
module rsq_demod (
    input wire clk_in,
    input wire [7:0] level_in,
    output reg bit_valid_out = 1'b0,
    output reg bit_out = 1'b0,
    output wire tick_out,
    output reg [7:0] rssi_out = 8'h80
);
    // Filter ticks every clock so RSSI settles within tens of cycles
    assign tick_out = 1'b1;
    always @(posedge clk_in) rssi_out <= level_in;
    // Bits go MSB first; the line flips between strobes so no stale bit lingers
    task send(input [63:0] bits, input integer n, input integer gap);
        integer i;
        begin
            for (i = n - 1; i >= 0; i = i - 1) begin
                @(posedge clk_in);
                bit_valid_out <= 1'b1;
                bit_out <= bits[i];
                @(posedge clk_in);
                bit_valid_out <= 1'b0;
                bit_out <= ~bits[i];
                repeat (gap) @(posedge clk_in);
            end
        end
    endtask
endmodule // rsq_demod

// file: verif/test_rx_signal_qualifiers.sv
// Self-checking bench for the receive qualifiers
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons = comparisons + 1; if ((s) !== (e)) begin \
err_count = err_count + 1; $display("mismatch %s exp %h got %h", n, e, s); end end
module test_rx_signal_qualifiers;
    reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rx_enter = 1'b0, pkt_end = 1'b0;
    reg [7:0] addr = 8'h00, wdata = 8'h00, dev = 8'h00, level = 8'h80, rv, lvl;
    wire [7:0] rdata, raw, dev_o;
    wire bv, bit_in, tick, bit_o, sync, fifo, gpo;
    integer err_count = 0, comparisons = 0, m, hi;
    always #5 clk = ~clk;
    always @(posedge clk) dev <= $urandom;
    rsq_demod u_dm (.clk_in(clk), .level_in(level), .bit_valid_out(bv), .bit_out(bit_in),
        .tick_out(tick), .rssi_out(raw));
    rsq_top dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BIT_VALID_IN(bv), .BIT_IN(bit_in),
        .RX_ENTER_IN(rx_enter), .PKT_END_IN(pkt_end), .CHAN_TICK_IN(tick),
        .RSSI_RAW_IN(raw), .DEV_IN(dev), .BIT_OUT(bit_o), .DEV_OUT(dev_o),
        .SYNC_FOUND_OUT(sync), .FIFO_WR_EN_OUT(fifo), .GPO_OUT(gpo));
    function exp_sync(input [2:0] md, input cs);
        exp_sync = (md[1:0] != 2'b10) && (!md[2] || cs);
    endfunction
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            {addr, wdata, wr} <= {a, d, 1'b1};
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge clk);
            {addr, rd} <= {a, 1'b1};
            @(posedge clk);
            rd <= 1'b0;
            #1 rv = rdata;
        end
    endtask
    task rx_start;
        begin
            @(posedge clk) rx_enter <= 1'b1;
            @(posedge clk) rx_enter <= 1'b0;
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #200000 err_count = err_count + 1;
        close_out;
    end
    initial begin
        m = $urandom(59);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h3c); `CHK("unmapped", 8'h00, rv)
        wr_reg(8'h02, 8'h00);
        wr_reg(8'h05, 8'h0e);
        // One bit wrong per half: 15/16 and 30/32 pass, 16/16 fails
        for (m = 0; m < 8; m = m + 1) begin
            hi = $urandom % 2;
            lvl = hi ? 8'h30 + $urandom % 80 : 8'h80 + $urandom % 96;
            level <= lvl;
            rx_start;
            wr_reg(8'h00, {1'b0, ($urandom % 2) ? 3'h3 : 3'h0, 1'b0, m[2:0]});
            repeat (40) @(posedge clk);
            rd_reg(8'h06); `CHK("carrier", hi[0], rv[6])
            `CHK("gpo cs", hi[0], gpo)
            u_dm.send(64'hd390_d390, 32, m % 3);
            // Sync rises one cycle after the completing bit
            @(posedge clk);
            #1 `CHK("sync", exp_sync(m[2:0], hi[0]), sync)
        end
        lvl = 8'h90 + $urandom % 64;
        level <= lvl;
        rx_start;
        wr_reg(8'h00, 8'h02);
        repeat (40) @(posedge clk);
        rd_reg(8'h07); `CHK("rssi", lvl, rv)
        u_dm.send(64'hd391, 16, 1);
        #1 `CHK("sync exact", 1'b1, sync)
        level <= lvl + 8'h20;
        repeat (40) @(posedge clk);
        rd_reg(8'h07); `CHK("rssi frozen", lvl, rv)
        @(posedge clk) pkt_end <= 1'b1;
        @(posedge clk) pkt_end <= 1'b0;
        repeat (20) @(posedge clk);
        rd_reg(8'h07); `CHK("rssi held", lvl, rv)
        // Appended byte is the last level measured while the packet ran
        rd_reg(8'h08); `CHK("append", lvl + 8'h20, rv)
        rx_start;
        repeat (40) @(posedge clk);
        rd_reg(8'h07); `CHK("rssi thaw", lvl + 8'h20, rv)
        // Threshold seven gives a gate of 28 transitions
        wr_reg(8'h01, 8'he4);
        wr_reg(8'h05, 8'h08);
        wr_reg(8'h00, 8'h72);
        rx_start;
        u_dm.send(64'haaaa_aaaa, 27, 0);
        rd_reg(8'h06); `CHK("pq low", 1'b0, rv[5])
        u_dm.send(64'h5, 3, 2);
        rd_reg(8'h06); `CHK("pq hit", 1'b1, rv[5])
        `CHK("gpo pq", 1'b1, gpo)
        u_dm.send(64'h1, 1, 0);
        rd_reg(8'h06); `CHK("pq drop", 1'b0, rv[5])
        // MSK inverts the line, so the inverted word reaches the window as the true one
        u_dm.send(64'h2c6e_2c6e, 32, 0);
        @(posedge clk);
        #1 `CHK("sync gated", 1'b0, sync)
        close_out;
    end
endmodule // test_rx_signal_qualifiers
